// [design/dma_dest_trig.sv]
// Function
// RULE_01 - Destination pointer is 16-bit read-only, low and high bytes, reset zero
// RULE_02 - Destination size is 12 bits writable; high byte bits 7-4 read zero
// RULE_03 - Destination byte count is 12-bit read-only; upper high bits read zero
// RULE_04 - Start selector is a 7-bit writable code; bit 7 reads zero
// RULE_05 - Abort selector is a 7-bit code, same map; bit 7 reads zero
// RULE_06 - Code zero, codes from 0x52 up and scattered holes trigger nothing
// RULE_07 - Pin-change and serial receive/transmit/error sources are level; others are edge
// RULE_08 - Trigger on the event setting a flag; the flag is never cleared here
// RULE_09 - Abort trigger stops a transfer only while abort enable is set
// RULE_10 - In-progress set while buffer holds unwritten data; cleared once written
// RULE_11 - Source reload with stop option clears start-trigger enable
// RULE_12 - Each written byte decrements count; exhaustion reloads count and pointer
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module dma_dest_trig (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Register bus
   input wire dma_pkg::avl_req_s avl_i,
   output var dma_pkg::avl_rsp_s avl_o,
   // Peripheral interrupt flags, indexed by code
   input wire logic [dma_pkg::NCODE-1:0] evt_flag_i,
   // Channel strobes
   input wire dma_pkg::chan_s chan_i,
   // Channel status
   output logic go_o,
   output logic xip_o,
   output logic [15:0] dst_addr_o,
   output logic start_o,
   output logic abort_o,
   output logic irq_o
);
   // ==========================================
   // State
   typedef struct packed {
      logic en;
      logic start_trigger_enable;
      logic go;
      logic abort_trigger_enable;
      logic transfer_in_progress;
      logic [1:0] dmode;
      logic dst_reload_stop;
      logic [1:0] smr;
      logic [1:0] smode;
      logic src_reload_stop;
      logic [7:0] buf_data;
      logic [15:0] dest_start_address;
      logic [15:0] dest_addr_pointer;
      logic [11:0] dest_message_size;
      logic [11:0] dest_byte_count;
      logic [6:0] start_trigger_code;
      logic [6:0] abort_trigger_code;
      logic [dma_pkg::NIRQ-1:0] ist;
      logic [dma_pkg::NIRQ-1:0] imsk;
      logic [dma_pkg::NCODE-1:0] prev;
      logic wait_rq;
      logic [31:0] rdata;
      logic start_p;
      logic abort_p;
      logic irq;
   } st_s;

   st_s q;
   st_s n;
   logic [5:0] idx;
   logic newrq;
   logic acc_wr;
   logic [7:0] wd;
   logic [7:0] rb;
   logic start_hit;
   logic abort_hit;
   logic dreload;
   logic [dma_pkg::NIRQ-1:0] ev;

   // ==========================================
   // Code map
   function automatic logic code_valid(input logic [6:0] c);
      logic v;
      v = (c != dma_pkg::CODE_NONE) && (c < dma_pkg::CODE_FIRST_FREE);
      if (c == 7'h24 || c == 7'h3A) begin
         v = 1'b0;
      end
      if ((c >= 7'h3E && c <= 7'h45) || (c >= 7'h4C && c <= 7'h4F)) begin
         v = 1'b0;
      end
      return v;
   endfunction

   function automatic logic code_level(input logic [6:0] c);
      return (c == 7'h07) || (c >= 7'h14 && c <= 7'h1D)
         || (c >= 7'h2E && c <= 7'h34);
   endfunction

   // Edge sources fire on the flag's rise only; flags stay untouched
   function automatic logic trig_hit(
      input logic [6:0] c,
      input logic [dma_pkg::NCODE-1:0] f,
      input logic [dma_pkg::NCODE-1:0] p
   );
      logic h;
      h = 1'b0;
      if (code_valid(c)) begin // see RULE_06
         h = code_level(c) ? f[c] : (f[c] & ~p[c]); // see RULE_07 see RULE_08
      end
      return h;
   endfunction

   function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m);
      logic [15:0] r;
      case (dma_pkg::dmode_e'(m))
         dma_pkg::DM_INC: r = a + 16'h0001;
         dma_pkg::DM_DEC: r = a - 16'h0001;
         default: r = a;
      endcase
      return r;
   endfunction

   // ==========================================
   // Next state
   always_comb begin
      n = q;
      idx = avl_i.address[7:2];
      wd = avl_i.writedata[7:0];
      // A request is answered one edge after it is seen
      newrq = (avl_i.read | avl_i.write) & q.wait_rq;
      acc_wr = ~q.wait_rq & avl_i.write;
      n.wait_rq = ~newrq;
      n.prev = evt_flag_i;
      rb = dma_pkg::REG_RST;
      case (idx)
         dma_pkg::R_CON0: begin
            rb[dma_pkg::B_EN] = q.en;
            rb[dma_pkg::B_START_TRIGGER_ENABLE] = q.start_trigger_enable;
            rb[dma_pkg::B_GO] = q.go;
            rb[dma_pkg::B_ABORT_TRIGGER_ENABLE] = q.abort_trigger_enable;
            rb[dma_pkg::B_XIP] = q.transfer_in_progress;
         end
         dma_pkg::R_CON1: rb = {q.dmode, q.dst_reload_stop, q.smr, q.smode, q.src_reload_stop};
         dma_pkg::R_BUF: rb = q.buf_data;
         dma_pkg::R_DSAL: rb = q.dest_start_address[7:0];
         dma_pkg::R_DSAH: rb = q.dest_start_address[15:8];
         dma_pkg::R_DPTRL: rb = q.dest_addr_pointer[7:0]; // see RULE_01
         dma_pkg::R_DPTRH: rb = q.dest_addr_pointer[15:8]; // see RULE_01
         dma_pkg::R_DSZL: rb = q.dest_message_size[7:0];
         dma_pkg::R_DSZH: rb = {4'h0, q.dest_message_size[11:8]}; // see RULE_02
         dma_pkg::R_DCNTL: rb = q.dest_byte_count[7:0];
         dma_pkg::R_DCNTH: rb = {4'h0, q.dest_byte_count[11:8]}; // see RULE_03
         dma_pkg::R_START_TRIGGER_CODE: rb = {1'b0, q.start_trigger_code}; // see RULE_04
         dma_pkg::R_ABORT_TRIGGER_CODE: rb = {1'b0, q.abort_trigger_code}; // see RULE_05
         dma_pkg::R_IST: rb = {5'h00, q.ist};
         dma_pkg::R_IMSK: rb = {5'h00, q.imsk};
         default: rb = dma_pkg::REG_RST;
      endcase
      if (newrq & avl_i.read) begin
         n.rdata = {24'h000000, rb};
      end
      // Software writes, taken on the accepting edge
      if (acc_wr) begin
         case (idx)
            dma_pkg::R_CON0: begin
               n.en = wd[dma_pkg::B_EN];
               n.start_trigger_enable = wd[dma_pkg::B_START_TRIGGER_ENABLE];
               n.go = wd[dma_pkg::B_GO];
               n.abort_trigger_enable = wd[dma_pkg::B_ABORT_TRIGGER_ENABLE];
               // Arming the channel starts a fresh message
               if (wd[dma_pkg::B_EN] & ~q.en) begin
                  n.dest_byte_count = q.dest_message_size;
                  n.dest_addr_pointer = q.dest_start_address;
               end
            end
            dma_pkg::R_CON1: begin
               n.dmode = wd[7:6];
               n.dst_reload_stop = wd[dma_pkg::B_DST_RELOAD_STOP];
               n.smr = wd[4:3];
               n.smode = wd[2:1];
               n.src_reload_stop = wd[dma_pkg::B_SRC_RELOAD_STOP];
            end
            dma_pkg::R_DSAL: n.dest_start_address[7:0] = wd;
            dma_pkg::R_DSAH: n.dest_start_address[15:8] = wd;
            dma_pkg::R_DSZL: n.dest_message_size[7:0] = wd; // see RULE_02
            dma_pkg::R_DSZH: n.dest_message_size[11:8] = wd[3:0]; // see RULE_02
            dma_pkg::R_START_TRIGGER_CODE: n.start_trigger_code = wd[6:0]; // see RULE_04
            dma_pkg::R_ABORT_TRIGGER_CODE: n.abort_trigger_code = wd[6:0]; // see RULE_05
            dma_pkg::R_IMSK: n.imsk = wd[dma_pkg::NIRQ-1:0];
            default: n.en = n.en;
         endcase
      end
      // Triggers
      start_hit = q.en & q.start_trigger_enable & trig_hit(q.start_trigger_code, evt_flag_i, q.prev);
      abort_hit = q.en & q.abort_trigger_enable & trig_hit(q.abort_trigger_code, evt_flag_i, q.prev); // see RULE_09
      n.start_p = start_hit;
      n.abort_p = abort_hit;
      if (start_hit) begin
         n.go = 1'b1;
      end
      // Destination side
      dreload = 1'b0;
      if (q.en & chan_i.dst_write) begin
         if (q.dest_byte_count <= 12'h001) begin
            dreload = 1'b1;
            n.dest_byte_count = q.dest_message_size; // see RULE_12
            n.dest_addr_pointer = q.dest_start_address; // see RULE_12
            n.go = 1'b0;
            if (q.dst_reload_stop) begin
               n.start_trigger_enable = 1'b0;
            end
         end else begin
            n.dest_byte_count = q.dest_byte_count - 12'h001; // see RULE_12
            n.dest_addr_pointer = step(q.dest_addr_pointer, q.dmode);
         end
      end
      // Abort beats a start in the same cycle
      if (abort_hit) begin
         n.go = 1'b0; // see RULE_09
      end
      if (q.src_reload_stop & chan_i.src_reload) begin
         n.start_trigger_enable = 1'b0; // see RULE_11
      end
      // New data beats the write-out of old data
      if (chan_i.dst_write) begin
         n.transfer_in_progress = 1'b0; // see RULE_10
      end
      if (chan_i.buf_load) begin
         n.transfer_in_progress = 1'b1; // see RULE_10
         n.buf_data = chan_i.buf_data;
      end
      // Sticky status, cleared by its read; a new event wins
      ev = '0;
      ev[dma_pkg::I_START] = start_hit;
      ev[dma_pkg::I_ABORT] = abort_hit;
      ev[dma_pkg::I_DDONE] = dreload;
      if (newrq & avl_i.read & (idx == dma_pkg::R_IST)) begin
         n.ist = ev;
      end else begin
         n.ist = q.ist | ev;
      end
      n.irq = |(n.ist & n.imsk);
   end

   // ==========================================
   // Registers
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
         q.wait_rq <= dma_pkg::WAIT_RST;
      end else if (ce_i) begin
         q <= n;
      end
   end

   assign avl_o.readdata = q.rdata;
   assign avl_o.waitrequest = q.wait_rq;
   assign go_o = q.go;
   assign xip_o = q.transfer_in_progress;
   assign dst_addr_o = q.dest_addr_pointer;
   assign start_o = q.start_p;
   assign abort_o = q.abort_p;
   assign irq_o = q.irq;

   // ==========================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_rd(logic [5:0] r);
      ce_i && !q.wait_rq && avl_i.read && avl_i.address[7:2] == r;
   endsequence

   sequence s_wr(logic [5:0] r);
      ce_i && !q.wait_rq && avl_i.write && avl_i.address[7:2] == r;
   endsequence

   property p_ptr_ro;
      s_wr(dma_pkg::R_DPTRL) and (!chan_i.dst_write) |=> $stable(q.dest_addr_pointer);
   endproperty
   a_ptr_ro: assert property (p_ptr_ro) else $error("pointer written by bus"); // see RULE_01

   property p_dsz_hi;
      s_rd(dma_pkg::R_DSZH) |-> avl_o.readdata[7:4] == 4'h0;
   endproperty
   a_dsz_hi: assert property (p_dsz_hi) else $error("size high bits set"); // see RULE_02

   property p_dest_byte_count_hi;
      s_rd(dma_pkg::R_DCNTH) |-> avl_o.readdata[31:4] == 28'h0000000;
   endproperty
   a_dest_byte_count_hi: assert property (p_dest_byte_count_hi) else $error("count high bits set"); // see RULE_03

   property p_start_trigger_code_rt;
      s_rd(dma_pkg::R_START_TRIGGER_CODE) |-> avl_o.readdata[31:7] == 25'h0;
   endproperty
   a_start_trigger_code_rt: assert property (p_start_trigger_code_rt) else $error("start select bit 7 set"); // see RULE_04

   property p_abort_trigger_code_top;
      s_rd(dma_pkg::R_ABORT_TRIGGER_CODE) |-> avl_o.readdata[7] == 1'b0;
   endproperty
   a_abort_trigger_code_top: assert property (p_abort_trigger_code_top) else $error("abort select bit 7 set"); // see RULE_05

   property p_reserved;
      q.start_p |-> code_valid($past(q.start_trigger_code));
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code fired"); // see RULE_06

   property p_edge_once;
      ce_i && $stable(q.start_trigger_code) && q.start_p ##1 ce_i && q.start_p
         |-> code_level($past(q.start_trigger_code));
   endproperty
   a_edge_once: assert property (p_edge_once) else $error("edge fired twice"); // see RULE_07

   property p_abort_gate;
      // A same-edge write lands too late to matter
      ce_i && !q.abort_trigger_enable |=> !q.abort_p;
   endproperty
   a_abort_gate: assert property (p_abort_gate) else $error("abort while disabled"); // see RULE_09

   property p_xip;
      ce_i && chan_i.buf_load |=> q.transfer_in_progress [*1] ##0 (q.buf_data == $past(chan_i.buf_data));
   endproperty
   a_xip: assert property (p_xip) else $error("in-progress not set"); // see RULE_10

   property p_src_reload_stop;
      ce_i && q.src_reload_stop && chan_i.src_reload |=> !q.start_trigger_enable;
   endproperty
   a_src_reload_stop: assert property (p_src_reload_stop) else $error("enable kept on reload"); // see RULE_11

   property p_reload;
      ce_i && q.en && chan_i.dst_write && q.dest_byte_count == 12'h001
         |=> q.dest_byte_count == $past(q.dest_message_size) && q.dest_addr_pointer == $past(q.dest_start_address) && !q.go;
   endproperty
   a_reload: assert property (p_reload) else $error("count not reloaded"); // see RULE_12

   property p_bus;
      ce_i && !q.wait_rq |=> q.wait_rq;
   endproperty
   a_bus: assert property (p_bus) else $error("waitrequest low twice");

   // Edge source: every rise of its flag is taken
   property p_edge_rise;
      ce_i && q.en && q.start_trigger_enable && code_valid(q.start_trigger_code) && !code_level(q.start_trigger_code)
         && evt_flag_i[q.start_trigger_code] && !q.prev[q.start_trigger_code] |=> q.start_p;
   endproperty
   a_edge_rise: assert property (p_edge_rise) else $error("flag rise missed"); // see RULE_08

   // Level source: fires on every cycle its flag stands
   property p_level_hold;
      ce_i && q.en && q.start_trigger_enable && code_valid(q.start_trigger_code) && code_level(q.start_trigger_code)
         && evt_flag_i[q.start_trigger_code] |=> q.start_p;
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("level missed"); // see RULE_07

   property p_abort_wins;
      ce_i && abort_hit |=> !q.go && q.abort_p;
   endproperty
   a_abort_wins: assert property (p_abort_wins) else $error("go kept after abort"); // see RULE_09

   property p_count_step;
      ce_i && q.en && chan_i.dst_write && q.dest_byte_count > 12'h001
         |=> q.dest_byte_count == $past(q.dest_byte_count) - 12'h001;
   endproperty
   a_count_step: assert property (p_count_step) else $error("count not stepped"); // see RULE_12

   // Enable low must hold every bit, bus answer included
   property p_freeze;
      !ce_i |=> $stable(q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   property p_irq;
      q.irq == |(q.ist & q.imsk);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule
`default_nettype wire

// [design/dma_pkg.sv]
package dma_pkg;
   // ==========================================
   // Register indices (byte address = 4 * index)
   localparam logic [5:0] R_CON0 = 6'h00;
   localparam logic [5:0] R_CON1 = 6'h01;
   localparam logic [5:0] R_BUF = 6'h02;
   localparam logic [5:0] R_DSAL = 6'h03;
   localparam logic [5:0] R_DSAH = 6'h04;
   localparam logic [5:0] R_DPTRL = 6'h05;
   localparam logic [5:0] R_DPTRH = 6'h06;
   localparam logic [5:0] R_DSZL = 6'h07;
   localparam logic [5:0] R_DSZH = 6'h08;
   localparam logic [5:0] R_DCNTL = 6'h09;
   localparam logic [5:0] R_DCNTH = 6'h0A;
   localparam logic [5:0] R_START_TRIGGER_CODE = 6'h0B;
   localparam logic [5:0] R_ABORT_TRIGGER_CODE = 6'h0C;
   localparam logic [5:0] R_IST = 6'h0D;
   localparam logic [5:0] R_IMSK = 6'h0E;
   // ==========================================
   // Field positions
   localparam int B_EN = 7;
   localparam int B_START_TRIGGER_ENABLE = 6;
   localparam int B_GO = 5;
   localparam int B_ABORT_TRIGGER_ENABLE = 2;
   localparam int B_XIP = 0;
   localparam int B_DMODE = 6;
   localparam int B_DST_RELOAD_STOP = 5;
   localparam int B_SRC_RELOAD_STOP = 0;
   localparam int I_START = 0;
   localparam int I_ABORT = 1;
   localparam int I_DDONE = 2;
   localparam int NIRQ = 3;
   // ==========================================
   // Trigger code map
   localparam int CODE_W = 7;
   localparam int NCODE = 128;
   localparam logic [6:0] CODE_NONE = 7'h00;
   localparam logic [6:0] CODE_FIRST_FREE = 7'h52;
   // ==========================================
   // Reset values
   localparam logic WAIT_RST = 1'b1;
   localparam logic [7:0] REG_RST = 8'h00;
   typedef enum logic [1:0] {
      DM_HOLD = 2'b00,
      DM_INC = 2'b01,
      DM_DEC = 2'b10,
      DM_RSVD = 2'b11
   } dmode_e;
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } avl_req_s;
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } avl_rsp_s;
   typedef struct packed {
      logic buf_load;
      logic [7:0] buf_data;
      logic dst_write;
      logic src_reload;
   } chan_s;
endpackage

// [tb/periph_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ====================
// Peripheral flags and channel strobes
module periph_model (
   // Clock
   input wire logic clk_i,
   // Toward the channel
   output var logic [127:0] evt_flag_o,
   output var dma_pkg::chan_s chan_o
);
   initial begin
      evt_flag_o = '0;
      chan_o = '0;
   end
   // Flag stays up until the peripheral drops it, never on a trigger
   task automatic put(input int code, input logic v);
      @(posedge clk_i);
      evt_flag_o[code] <= v;
   endtask
   // One-cycle strobe, k = {buf_load, dst_write, src_reload}
   task automatic pulse(input logic [2:0] k, input logic [7:0] d);
      @(posedge clk_i);
      chan_o <= '{k[2], d, k[1], k[0]};
      @(posedge clk_i);
      chan_o <= '{1'b0, ~d, 1'b0, 1'b0};
   endtask
endmodule
`default_nettype wire

// [tb/test_dma_dest_trig.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dma_dest_trig;
   logic clk_i, rst_b_i, ce_i, go, transfer_in_progress, start, abort, irq;
   dma_pkg::avl_req_s req;
   dma_pkg::avl_rsp_s rsp;
   dma_pkg::chan_s chan;
   logic [127:0] flags;
   logic [15:0] addr;
   logic [31:0] rd;
   int fails, samples_checked, cycles, n_start, n_abort, seed, s0, a0, code, k, cnt, ptr;
   int go_m;
   int tbl[16] = '{8'h00, 8'h01, 8'h07, 8'h14, 8'h1D, 8'h1E, 8'h24, 8'h2E, 8'h34, 8'h35,
      8'h3A, 8'h40, 8'h4F, 8'h51, 8'h52, 8'h7F};
   dma_dest_trig i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .avl_i(req),
      .avl_o(rsp), .evt_flag_i(flags), .chan_i(chan), .go_o(go), .xip_o(transfer_in_progress),
      .dst_addr_o(addr), .start_o(start), .abort_o(abort), .irq_o(irq));
   periph_model i_periph (.clk_i(clk_i), .evt_flag_o(flags), .chan_o(chan));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // ====================
   // Pulse counters and hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (start === 1'b1) n_start++;
      if (abort === 1'b1) n_abort++;
      if (cycles == 20000) begin
         fails++;
         final_report();
      end
   end
   // ====================
   // Helpers
   task automatic final_report();
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] wd);
      @(posedge clk_i);
      req <= '{~w, w, {idx, 2'b00}, {24'h0, wd}};
      // No timeout here; only the cycle ceiling ends a wait that never sees waitrequest low
      do begin
         @(posedge clk_i);
      end while (rsp.waitrequest !== 1'b0);
      rd = rsp.readdata;
      req <= '{1'b0, 1'b0, ~{idx, 2'b00}, 32'h0};
   endtask
   task automatic rchk(input string nm, input logic [5:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 8'h00);
      check(nm, rd, exp);
   endtask
   // Pulses expected from a flag held for three cycles
   function automatic int fires(input int c);
      if (c == 0 || c == 8'h24 || c == 8'h3A || (c >= 8'h3E && c <= 8'h45) ||
         (c >= 8'h4C && c <= 8'h4F) || c >= 8'h52) return 0;
      if (c == 7 || (c >= 8'h14 && c <= 8'h1D) || (c >= 8'h2E && c <= 8'h34)) return 3;
      return 1;
   endfunction
   task automatic shot(input int c);
      s0 = n_start;
      a0 = n_abort;
      i_periph.put(c, 1'b1);
      tick(2);
      i_periph.put(c, 1'b0);
      tick(4);
   endtask
   // ====================
   // Main sequence
   initial begin
      seed = 46;
      rst_b_i = 1'b0;
      ce_i = 1'b1;
      req = '0;
      tick(2);
      rst_b_i <= 1'b1;
      for (k = 5; k <= 12; k++) rchk("reset value", k[5:0], 32'h0);
      bus(1'b1, dma_pkg::R_DSZH, 8'hFF);
      rchk("size high", dma_pkg::R_DSZH, 32'h0F);
      bus(1'b1, dma_pkg::R_START_TRIGGER_CODE, 8'hFF);
      rchk("start select", dma_pkg::R_START_TRIGGER_CODE, 32'h7F);
      bus(1'b1, dma_pkg::R_ABORT_TRIGGER_CODE, 8'hD5);
      rchk("abort select", dma_pkg::R_ABORT_TRIGGER_CODE, 32'h55);
      bus(1'b1, dma_pkg::R_DPTRL, 8'hA5);
      rchk("pointer low", dma_pkg::R_DPTRL, 32'h0);
      bus(1'b1, dma_pkg::R_DCNTH, 8'hFF);
      rchk("count high", dma_pkg::R_DCNTH, 32'h0);
      rchk("unmapped", 6'h3F, 32'h0);
      bus(1'b1, dma_pkg::R_ABORT_TRIGGER_CODE, 8'h00);
      bus(1'b1, dma_pkg::R_CON0, 8'hC0);
      for (k = 0; k < 22; k++) begin
         code = (k < 16) ? tbl[k] : ($random(seed) & 127);
         bus(1'b1, dma_pkg::R_START_TRIGGER_CODE, code[7:0]);
         shot(code);
         check("start pulses", n_start - s0, fires(code));
         if (fires(code) > 0) go_m = 1;
         check("go", go, go_m);
      end
      bus(1'b1, dma_pkg::R_START_TRIGGER_CODE, 8'h00);
      bus(1'b1, dma_pkg::R_ABORT_TRIGGER_CODE, 8'h01);
      bus(1'b1, dma_pkg::R_CON0, 8'h80);
      shot(1);
      check("abort off", n_abort - a0, 0);
      bus(1'b1, dma_pkg::R_CON0, 8'hA4);
      shot(1);
      check("abort on", n_abort - a0, 1);
      check("go after abort", go, 0);
      bus(1'b1, dma_pkg::R_IMSK, 8'h00);
      bus(1'b0, dma_pkg::R_IST, 8'h00);
      shot(1);
      check("masked irq", irq, 0);
      bus(1'b1, dma_pkg::R_IMSK, 8'h02);
      tick(2);
      check("irq", irq, 1);
      rchk("status", dma_pkg::R_IST, 32'h02);
      tick(2);
      check("irq cleared", irq, 0);
      bus(1'b1, dma_pkg::R_CON0, 8'hC0);
      bus(1'b1, dma_pkg::R_CON1, 8'h01);
      i_periph.pulse(3'b001, 8'h00);
      rchk("enable after stop", dma_pkg::R_CON0, 32'h80);
      bus(1'b1, dma_pkg::R_CON0, 8'hC0);
      bus(1'b1, dma_pkg::R_CON1, 8'h00);
      i_periph.pulse(3'b001, 8'h00);
      rchk("enable kept", dma_pkg::R_CON0, 32'hC0);
      // Channel walk: size 3, increment mode
      bus(1'b1, dma_pkg::R_CON0, 8'h00);
      bus(1'b1, dma_pkg::R_DSAL, 8'h34);
      bus(1'b1, dma_pkg::R_DSAH, 8'h12);
      bus(1'b1, dma_pkg::R_DSZL, 8'h03);
      bus(1'b1, dma_pkg::R_DSZH, 8'h00);
      bus(1'b1, dma_pkg::R_CON1, 8'h40);
      bus(1'b1, dma_pkg::R_CON0, 8'h80);
      bus(1'b0, dma_pkg::R_IST, 8'h00);
      cnt = 3;
      ptr = 16'h1234;
      check("start pointer", addr, ptr);
      for (k = 1; k <= 3; k++) begin
         i_periph.pulse(3'b100, k[7:0]);
         tick(1);
         check("in progress", transfer_in_progress, 1);
         i_periph.pulse(3'b010, 8'h00);
         tick(1);
         check("drained", transfer_in_progress, 0);
         if (cnt <= 1) begin
            cnt = 3;
            ptr = 16'h1234;
         end else begin
            cnt--;
            ptr++;
         end
         check("pointer", addr, ptr);
         rchk("count", dma_pkg::R_DCNTL, cnt);
      end
      rchk("buffer", dma_pkg::R_BUF, 32'h03);
      rchk("reload status", dma_pkg::R_IST, 32'h04);
      // Enable low: a destination write must leave no trace
      ce_i <= 1'b0;
      i_periph.pulse(3'b010, 8'h00);
      ce_i <= 1'b1;
      tick(1);
      check("frozen pointer", addr, 16'h1234);
      rchk("frozen count", dma_pkg::R_DCNTL, 32'h03);
      // Decrement mode with reload stop
      bus(1'b1, dma_pkg::R_CON0, 8'hC0);
      bus(1'b1, dma_pkg::R_CON1, 8'hA0);
      for (k = 1; k <= 3; k++) begin
         i_periph.pulse(3'b010, 8'h00);
         tick(1);
         ptr = (k == 3) ? 16'h1234 : 16'h1234 - k;
         check("pointer down", addr, ptr);
      end
      rchk("enable after reload", dma_pkg::R_CON0, 32'h80);
      final_report();
   end
endmodule
`default_nettype wire
